// ==== core/ulim_regs.svh ====
// Purpose: register offsets, bit positions and reset values of the
//          uart interrupt level select and mask block
// Assumes: 32-bit apb data, 12-bit byte address, one word per register
// Notes:   definitions only
`ifndef ULIM_REGS_SVH
`define ULIM_REGS_SVH

// apb byte offsets
`define ULIM_ADDR_W 12
`define ULIM_OFF_LEVEL_SEL 12'h000
`define ULIM_OFF_MASK 12'h004
`define ULIM_OFF_RAW 12'h008
`define ULIM_OFF_MASKED 12'h00c
`define ULIM_OFF_CLEAR 12'h010

// level select fields
`define ULIM_LVL_W 6
`define ULIM_RX_SEL_HI 5
`define ULIM_RX_SEL_LO 3
`define ULIM_TX_SEL_HI 2
`define ULIM_TX_SEL_LO 0
`define ULIM_LVL_RESET 6'h12

// source bit positions, shared by mask, raw, masked and clear
`define ULIM_SRC_W 11
`define ULIM_BIT_OVERRUN 10
`define ULIM_BIT_BREAK 9
`define ULIM_BIT_PARITY 8
`define ULIM_BIT_FRAMING 7
`define ULIM_BIT_RX_TIMEOUT 6
`define ULIM_BIT_TX 5
`define ULIM_BIT_RX 4
`define ULIM_BIT_CTS 1
`define ULIM_SRC_VALID 11'h7f2
`define ULIM_MASK_RESET 11'h000
`define ULIM_RAW_RESET 11'h000

// fifo depth in entries
`define ULIM_FIFO_DEPTH 16

`endif

// ==== core/ulim_pkg.sv ====
// Purpose: shared types of the uart interrupt level select and mask block
// Assumes: nothing beyond the register header
// Notes:   trigger codes carry their register encoding
package ulim_pkg;

    // fifo trigger select codes; 3'h5 to 3'h7 are reserved
    typedef enum logic [2:0] {
        ULIM_TRIG_EIGHTH = 3'h0,
        ULIM_TRIG_QUARTER = 3'h1,
        ULIM_TRIG_HALF = 3'h2,
        ULIM_TRIG_THREE_QTR = 3'h3,
        ULIM_TRIG_SEVEN_EIGHTHS = 3'h4
    } ulim_trig_t;

    // one-cycle error pulses from the receive path
    typedef struct packed {
        logic overrun;
        logic brk;
        logic parity;
        logic framing;
        logic rx_timeout;
    } ulim_err_t;

endpackage

// ==== core/ulim_sync.sv ====
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to sys_clk_i
// Notes:   only the second stage may be read by other logic
`timescale 1ns/10ps
module ulim_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            meta_reg <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end

endmodule

// ==== core/ulim_level_detect.sv ====
// Purpose: fifo fill level crossing detector
// Assumes: fill count from logic on sys_clk_i
// Notes:   rising variant fires on filling up through the trigger,
//          falling variant on draining down through it
`timescale 1ns/10ps
`include "ulim_regs.svh"
module ulim_level_detect
    import ulim_pkg::*;
#(
    parameter int DEPTH = `ULIM_FIFO_DEPTH,
    parameter int CNT_W = $clog2(DEPTH + 1),
    parameter bit RISING = 1'b1
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // fill level and trigger select
    input wire logic [CNT_W-1:0] fill_i,
    input wire ulim_pkg::ulim_trig_t code_i,
    // one-cycle crossing pulse
    output logic cross_o
);

    localparam logic [CNT_W-1:0] T_EIGHTH = CNT_W'(DEPTH / 8);
    localparam logic [CNT_W-1:0] T_QUARTER = CNT_W'(DEPTH / 4);
    localparam logic [CNT_W-1:0] T_HALF = CNT_W'(DEPTH / 2);
    localparam logic [CNT_W-1:0] T_3QTR = CNT_W'((DEPTH * 3) / 4);
    localparam logic [CNT_W-1:0] T_7EIGHTHS = CNT_W'((DEPTH * 7) / 8);

    logic [CNT_W-1:0] prev_reg;
    logic cross_next;
    wire code_valid = (code_i <= ULIM_TRIG_SEVEN_EIGHTHS);
    wire [CNT_W-1:0] thr =
        (code_i == ULIM_TRIG_EIGHTH) ? T_EIGHTH :
        (code_i == ULIM_TRIG_QUARTER) ? T_QUARTER :
        (code_i == ULIM_TRIG_HALF) ? T_HALF :
        (code_i == ULIM_TRIG_THREE_QTR) ? T_3QTR : T_7EIGHTHS;
    // previous count, not a stored above/below flag, so a change of the
    // trigger code alone never looks like a crossing
    wire up_cross = (prev_reg < thr) && (fill_i >= thr);
    wire down_cross = (prev_reg > thr) && (fill_i <= thr);

    // reserved codes disable the detector
    assign cross_next = code_valid && (RISING ? up_cross : down_cross);

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            // track the count in reset: a fifo already past the trigger
            // when reset ends must not look like a crossing
            prev_reg <= fill_i;
            cross_o <= 1'b0;
        end else begin
            prev_reg <= fill_i;
            cross_o <= cross_next;
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_static_no_fire: assert property (
        $stable(fill_i) && !$past(sys_rst_i) |=> !cross_o)
        else $error("crossing pulse while fill level stood still");

    a_cross_fires: assert property (
        !$past(sys_rst_i) && code_valid &&
        (RISING ? ($past(fill_i) < thr && fill_i >= thr)
                : ($past(fill_i) > thr && fill_i <= thr)) |=> cross_o)
        else $error("fill level crossed trigger without a pulse");

endmodule

// ==== core/ulim_top.sv ====
// Purpose: uart interrupt front end: fifo trigger levels, source masks,
//          raw and masked status, clear, combined interrupt, apb slave
// Assumes: error pulses and fill counts are on sys_clk_i; cts pin is not
// Notes:   every apb transfer takes two access cycles
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "ulim_regs.svh"
module ulim_top #(
    parameter int FIFO_DEPTH = `ULIM_FIFO_DEPTH,
    parameter int CNT_W = $clog2(FIFO_DEPTH + 1)
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`ULIM_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // fifo fill counts and error pulses
    input wire logic [CNT_W-1:0] tx_fill_i,
    input wire logic [CNT_W-1:0] rx_fill_i,
    input wire ulim_pkg::ulim_err_t err_event_i,
    // modem pin, active low
    input wire logic clear_to_send_input_n_i,
    // interrupts
    output logic [`ULIM_SRC_W-1:0] masked_irq_o,
    output logic irq_o
);
    import ulim_pkg::*;

    logic [`ULIM_LVL_W-1:0] level_sel_reg;
    logic [`ULIM_LVL_W-1:0] level_sel_next;
    logic [`ULIM_SRC_W-1:0] mask_reg;
    logic [`ULIM_SRC_W-1:0] mask_next;
    logic [`ULIM_SRC_W-1:0] raw_reg;
    logic [`ULIM_SRC_W-1:0] raw_next;
    logic cts_prev_reg;
    logic cts_sync;
    logic tx_level_irq;
    logic rx_level_irq;

    // apb phase decode
    wire access = psel_i && penable_i;
    wire first_access = access && !pready_o;
    wire commit = access && pready_o;
    wire wr_commit = commit && pwrite_i;
    wire sel_level = (paddr_i == `ULIM_OFF_LEVEL_SEL);
    wire sel_mask = (paddr_i == `ULIM_OFF_MASK);
    wire sel_raw = (paddr_i == `ULIM_OFF_RAW);
    wire sel_masked = (paddr_i == `ULIM_OFF_MASKED);
    wire sel_clear = (paddr_i == `ULIM_OFF_CLEAR);
    wire mapped = sel_level || sel_mask || sel_raw || sel_masked || sel_clear;

    // trigger selects
    wire ulim_trig_t rx_trigger_select =
        ulim_trig_t'(level_sel_reg[`ULIM_RX_SEL_HI:`ULIM_RX_SEL_LO]);
    wire ulim_trig_t tx_trigger_select =
        ulim_trig_t'(level_sel_reg[`ULIM_TX_SEL_HI:`ULIM_TX_SEL_LO]);

    // receive fires on filling up, transmit on draining down
    ulim_level_detect #(
        .DEPTH(FIFO_DEPTH),
        .CNT_W(CNT_W),
        .RISING(1'b1)
    ) u_rx_level (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .fill_i(rx_fill_i),
        .code_i(rx_trigger_select),
        .cross_o(rx_level_irq)
    );

    ulim_level_detect #(
        .DEPTH(FIFO_DEPTH),
        .CNT_W(CNT_W),
        .RISING(1'b0)
    ) u_tx_level (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .fill_i(tx_fill_i),
        .code_i(tx_trigger_select),
        .cross_o(tx_level_irq)
    );

    ulim_sync #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_cts_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(clear_to_send_input_n_i),
        .sync_o(cts_sync)
    );

    // modem source fires on any change of the synchronised pin
    wire clear_to_send_irq = cts_sync ^ cts_prev_reg;

    // source events at their status positions
    wire [`ULIM_SRC_W-1:0] src_set = {
        err_event_i.overrun,
        err_event_i.brk,
        err_event_i.parity,
        err_event_i.framing,
        err_event_i.rx_timeout,
        tx_level_irq,
        rx_level_irq,
        2'b00,
        clear_to_send_irq,
        1'b0
    };

    wire [`ULIM_SRC_W-1:0] src_clear = (wr_commit && sel_clear) ?
        (pwdata_i[`ULIM_SRC_W-1:0] & `ULIM_SRC_VALID) : '0;

    // set wins over a clear in the same cycle
    assign raw_next = (raw_reg & ~src_clear) | src_set;

    // unsupported fields are dropped on write
    assign level_sel_next = (wr_commit && sel_level) ?
        pwdata_i[`ULIM_LVL_W-1:0] : level_sel_reg;
    assign mask_next = (wr_commit && sel_mask) ?
        (pwdata_i[`ULIM_SRC_W-1:0] & `ULIM_SRC_VALID) : mask_reg;

    wire [`ULIM_SRC_W-1:0] masked = raw_reg & mask_reg;
    wire [`ULIM_SRC_W-1:0] masked_next = raw_next & mask_next;

    // read mux; clear register is write-only and reads zero
    wire [31:0] rd_level = {{(32 - `ULIM_LVL_W){1'b0}}, level_sel_reg};
    wire [31:0] rd_mask = {{(32 - `ULIM_SRC_W){1'b0}}, mask_reg};
    wire [31:0] rd_raw = {{(32 - `ULIM_SRC_W){1'b0}}, raw_reg};
    wire [31:0] rd_masked = {{(32 - `ULIM_SRC_W){1'b0}}, masked};
    wire [31:0] rd_data =
        sel_level ? rd_level :
        sel_mask ? rd_mask :
        sel_raw ? rd_raw :
        sel_masked ? rd_masked : 32'h0000_0000;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= first_access;
            pslverr_o <= first_access && !mapped;
            if (first_access && !pwrite_i) begin
                prdata_o <= rd_data;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            level_sel_reg <= `ULIM_LVL_RESET;
            mask_reg <= `ULIM_MASK_RESET;
            raw_reg <= `ULIM_RAW_RESET;
            cts_prev_reg <= 1'b1;
            masked_irq_o <= '0;
            irq_o <= 1'b0;
        end else begin
            level_sel_reg <= level_sel_next;
            mask_reg <= mask_next;
            raw_reg <= raw_next;
            cts_prev_reg <= cts_sync;
            masked_irq_o <= masked_next;
            // registered from next values so it tracks masked status
            irq_o <= |masked_next;
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_level_reset: assert property (
        $past(sys_rst_i) |-> level_sel_reg == `ULIM_LVL_RESET)
        else $error("trigger selects not half full after reset");

    a_stat_reset: assert property (
        $past(sys_rst_i) |-> raw_reg == '0 && mask_reg == '0)
        else $error("raw status or mask not zero after reset");

    a_level_write: assert property (
        wr_commit && sel_level |=> level_sel_reg ==
            $past(pwdata_i[`ULIM_LVL_W-1:0]))
        else $error("trigger select write not stored");

    a_mask_write: assert property (
        wr_commit && sel_mask |=> mask_reg ==
            ($past(pwdata_i[`ULIM_SRC_W-1:0]) & `ULIM_SRC_VALID))
        else $error("mask write not stored");

    a_unused_zero: assert property (
        (mask_reg & ~`ULIM_SRC_VALID) == '0 &&
        (raw_reg & ~`ULIM_SRC_VALID) == '0)
        else $error("unsupported bit became set");

    a_raw_readonly: assert property (
        wr_commit && sel_raw && src_set == '0 |=> $stable(raw_reg))
        else $error("write to raw status changed it");

    a_overrun_set: assert property (
        err_event_i.overrun |=> raw_reg[`ULIM_BIT_OVERRUN])
        else $error("overrun pulse not captured at bit 10");

    a_clear_source: assert property (
        wr_commit && sel_clear && pwdata_i[`ULIM_BIT_OVERRUN] &&
        !err_event_i.overrun |=> !raw_reg[`ULIM_BIT_OVERRUN])
        else $error("overrun clear had no effect");

    a_irq_or_mask: assert property (
        !$past(sys_rst_i) |-> irq_o == |(raw_reg & mask_reg))
        else $error("combined interrupt differs from masked status");

    a_masked_read: assert property (
        first_access && !pwrite_i && sel_masked |=>
            prdata_o == {{(32 - `ULIM_SRC_W){1'b0}}, $past(masked)})
        else $error("masked view read wrong");

    a_rx_level_irq: assert property (
        rx_level_irq && mask_next[`ULIM_BIT_RX] |=>
            irq_o && raw_reg[`ULIM_BIT_RX])
        else $error("enabled receive level event did not interrupt");

    a_apb_answer: assert property (
        first_access |=> pready_o ##1 !pready_o)
        else $error("apb answer not exactly one cycle");

    c_rx_irq: cover property (rx_level_irq && mask_reg[`ULIM_BIT_RX]);
    c_tx_irq: cover property (tx_level_irq ##1 irq_o);
    c_set_clear: cover property (src_set[`ULIM_BIT_OVERRUN] &&
        src_clear[`ULIM_BIT_OVERRUN]);
    c_unmapped: cover property (pready_o && pslverr_o);

endmodule

// ==== test/ulim_top_tb.sv ====
// Purpose: self-checking bench of the uart interrupt front end
// Assumes: apb answers within 20 access cycles; fills on sys_clk_i
// Notes:   each scenario task drives the block and judges the result
`timescale 1ns/10ps
`include "ulim_regs.svh"
module ulim_top_tb;
    import ulim_pkg::*;
    localparam int DEPTH = 16;
    localparam int CW = $clog2(DEPTH + 1);
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [CW-1:0] tx_fill_i = '0;
    logic [CW-1:0] rx_fill_i = '0;
    ulim_err_t err_event_i = '0;
    logic clear_to_send_input_n_i = 1'b1;
    logic [10:0] masked_irq_o;
    logic irq_o;
    int fail_count = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic er;

    ulim_top #(.FIFO_DEPTH(DEPTH)) i_dut (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .tx_fill_i(tx_fill_i),
        .rx_fill_i(rx_fill_i),
        .err_event_i(err_event_i),
        .clear_to_send_input_n_i(clear_to_send_input_n_i),
        .masked_irq_o(masked_irq_o),
        .irq_o(irq_o)
    );

    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    task automatic final_report();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // request held until pready is sampled high; no latency is assumed
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (pready_o !== 1'b1) begin
            fail_count++;
            final_report();
        end
        @(posedge sys_clk_i);
    endtask

    task automatic rchk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(what, exp, rd);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    task automatic t_reset();
        rchk("level select", `ULIM_OFF_LEVEL_SEL, 32'h12);
        rchk("mask", `ULIM_OFF_MASK, 32'h0);
        rchk("raw", `ULIM_OFF_RAW, 32'h0);
        cmp("irq", 32'h0, {31'h0, irq_o});
    endtask

    task automatic t_regs();
        apb(1'b1, `ULIM_OFF_MASK, 32'hffffffff);
        rchk("mask all", `ULIM_OFF_MASK, 32'h7f2);
        apb(1'b1, `ULIM_OFF_MASK, 32'h410);
        rchk("mask some", `ULIM_OFF_MASK, 32'h410);
        apb(1'b1, `ULIM_OFF_MASK, 32'h0);
        apb(1'b1, `ULIM_OFF_LEVEL_SEL, 32'hfff);
        rchk("level unused", `ULIM_OFF_LEVEL_SEL, 32'h3f);
        apb(1'b1, `ULIM_OFF_RAW, 32'h7f2);
        rchk("raw write", `ULIM_OFF_RAW, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        cmp("unmapped error", 32'h1, {31'h0, er});
    endtask

    // error sources sit at bits 6 to 10, rx_timeout lowest
    task automatic t_errors();
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `ULIM_OFF_MASK, 32'h1 << (6 + i));
            err_event_i <= 5'h01 << i;
            @(posedge sys_clk_i);
            err_event_i <= '0;
            tick(2);
            rchk("raw error", `ULIM_OFF_RAW, 32'h1 << (6 + i));
            rchk("masked error", `ULIM_OFF_MASKED, 32'h1 << (6 + i));
            cmp("masked line", 32'h1 << (6 + i), {21'h0, masked_irq_o});
            cmp("irq error", 32'h1, {31'h0, irq_o});
            apb(1'b1, `ULIM_OFF_MASK, 32'h0);
            cmp("irq masked off", 32'h0, {31'h0, irq_o});
            apb(1'b1, `ULIM_OFF_CLEAR, 32'h1 << (6 + i));
            rchk("raw cleared", `ULIM_OFF_RAW, 32'h0);
        end
    endtask

    // overrun pulse stands on the edge at which its clear commits
    task automatic t_set_wins();
        int n;
        n = 0;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= 1'b1;
        paddr_i <= `ULIM_OFF_CLEAR;
        pwdata_i <= 32'h400;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        err_event_i.overrun <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        err_event_i <= '0;
        if (pready_o !== 1'b1) begin
            fail_count++;
            final_report();
        end
        @(posedge sys_clk_i);
        rchk("raw set wins", `ULIM_OFF_RAW, 32'h400);
        apb(1'b1, `ULIM_OFF_CLEAR, 32'h400);
        rchk("raw after clear", `ULIM_OFF_RAW, 32'h0);
    endtask

    // reset in mid-run with both fifos sitting at the half-full trigger
    task automatic t_rerun();
        apb(1'b1, `ULIM_OFF_MASK, 32'h7f2);
        apb(1'b1, `ULIM_OFF_LEVEL_SEL, 32'h9);
        err_event_i.overrun <= 1'b1;
        @(posedge sys_clk_i);
        err_event_i <= '0;
        tick(2);
        rchk("raw before reset", `ULIM_OFF_RAW, 32'h400);
        sys_rst_i <= 1'b1;
        tick(3);
        sys_rst_i <= 1'b0;
        tick(4);
        rchk("level rerun", `ULIM_OFF_LEVEL_SEL, 32'h12);
        rchk("mask rerun", `ULIM_OFF_MASK, 32'h0);
        rchk("raw rerun", `ULIM_OFF_RAW, 32'h0);
        cmp("irq rerun", 32'h0, {31'h0, irq_o});
    endtask

    // rx fires filling up to the trigger, tx draining down to it;
    // code 5 is reserved and must stay quiet
    task automatic t_levels();
        int k[5] = '{1, 2, 4, 6, 7};
        int t;
        apb(1'b1, `ULIM_OFF_MASK, 32'h30);
        for (int c = 0; c < 6; c++) begin
            t = (c < 5) ? DEPTH * k[c] / 8 : DEPTH / 2;
            apb(1'b1, `ULIM_OFF_LEVEL_SEL, {26'h0, c[2:0], c[2:0]});
            rx_fill_i <= CW'(t - 1);
            tx_fill_i <= CW'(t + 1);
            tick(4);
            rchk("raw before", `ULIM_OFF_RAW, 32'h0);
            rx_fill_i <= CW'(t);
            tx_fill_i <= CW'(t);
            tick(4);
            rchk("raw crossing", `ULIM_OFF_RAW, (c < 5) ? 32'h30 : 32'h0);
            cmp("irq level", {31'h0, (c < 5)}, {31'h0, irq_o});
            apb(1'b1, `ULIM_OFF_CLEAR, 32'h30);
            tick(4);
            rchk("raw static", `ULIM_OFF_RAW, 32'h0);
        end
        apb(1'b1, `ULIM_OFF_MASK, 32'h0);
    endtask

    task automatic t_cts();
        apb(1'b1, `ULIM_OFF_MASK, 32'h2);
        clear_to_send_input_n_i <= 1'b0;
        tick(6);
        rchk("raw cts", `ULIM_OFF_RAW, 32'h2);
        cmp("irq cts", 32'h1, {31'h0, irq_o});
        apb(1'b1, `ULIM_OFF_CLEAR, 32'h2);
        rchk("raw cts cleared", `ULIM_OFF_RAW, 32'h0);
        cmp("irq cts cleared", 32'h0, {31'h0, irq_o});
        clear_to_send_input_n_i <= 1'b1;
        tick(6);
        rchk("raw cts rise", `ULIM_OFF_RAW, 32'h2);
        apb(1'b1, `ULIM_OFF_CLEAR, 32'h2);
        rchk("raw cts rise cleared", `ULIM_OFF_RAW, 32'h0);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge sys_clk_i);
        t_reset();
        t_regs();
        t_errors();
        t_set_wins();
        t_levels();
        t_rerun();
        t_cts();
        final_report();
    end
endmodule
